// >>> logic/fbp_top.sv
// Flash access and block protection in front of the storage array
module fbp_top
    import fbp_pkg::*;
(
    input  wire logic            clk,        // 40 MHz system clock
    input  wire logic            sys_rst,    // Synchronous reset, active high
    input  wire logic [31:0]     ro_mask,    // Read-only flag per unit
    input  wire logic [31:0]     xo_mask,    // Execute-only flag per unit
    input  wire logic            rd_req,     // Read request
    input  wire fbp_pkg::fbp_src_t rd_src,   // Requesting path
    input  wire logic [15:0]     rd_addr,    // Read byte address
    output logic                 rd_ack,     // Read answered
    output logic                 rd_err,     // Read denied
    output logic [31:0]          rd_data,    // Read data
    input  wire logic            cmd_req,    // Erase or program request
    input  wire fbp_pkg::fbp_op_t cmd_op,    // Operation
    input  wire logic [15:0]     cmd_addr,   // Target byte address
    input  wire logic [31:0]     cmd_data,   // Program data
    output logic                 cmd_busy,   // Operation in progress
    output logic                 cmd_done,   // Operation finished
    output logic                 cmd_err     // Operation refused
);

    import fbp_pkg::*;

    // ------------------------------------------------------------
    // Protection decode
    // ------------------------------------------------------------
    function automatic logic unit_locked(input logic [15:0] a);
        return ro_mask[fbp_unit(a)] | xo_mask[fbp_unit(a)];
    endfunction

    logic rd_allow;
    logic cmd_take;
    logic cmd_deny;

    always_comb begin
        rd_allow = !xo_mask[fbp_unit(rd_addr)] || (rd_src == FBP_SRC_IFETCH);
        cmd_deny = unit_locked(cmd_addr);
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic rd_ack_r;
    logic rd_ack_nxt;
    logic rd_err_r;
    logic rd_err_nxt;
    logic mem_rd_en;

    always_comb begin
        rd_ack_nxt = rd_req;
        rd_err_nxt = rd_req && !rd_allow;
        mem_rd_en  = rd_req && rd_allow;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_ack_r <= 1'b0;
            rd_err_r <= 1'b0;
        end else begin
            rd_ack_r <= rd_ack_nxt;
            rd_err_r <= rd_err_nxt;
        end
    end

    assign rd_ack = rd_ack_r;
    assign rd_err = rd_err_r;

    // ------------------------------------------------------------
    // Erase and program sequencer
    // ------------------------------------------------------------
    fbp_state_t  state_r;
    fbp_state_t  state_nxt;
    logic [13:0] waddr_r;
    logic [13:0] waddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [7:0]  cnt_r;
    logic [7:0]  cnt_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        err_r;
    logic        err_nxt;
    logic        mem_wr_en;
    logic [13:0] mem_wr_addr;

    assign cmd_take = cmd_req && (state_r == FBP_ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        cnt_nxt   = cnt_r;
        done_nxt  = 1'b0;
        err_nxt   = 1'b0;
        case (state_r)
            FBP_ST_IDLE: begin
                if (cmd_take) begin
                    if (cmd_deny) begin
                        done_nxt = 1'b1;
                        err_nxt  = 1'b1;
                    end else if (cmd_op == FBP_OP_ERASE) begin
                        state_nxt = FBP_ST_ERASE;
                        waddr_nxt = {cmd_addr[15:FBP_BLK_LSB], FBP_CNT_RST};
                        wdata_nxt = FBP_ERASED_WORD;
                        cnt_nxt   = FBP_CNT_RST;
                    end else begin
                        state_nxt = FBP_ST_PROG;
                        waddr_nxt = fbp_word(cmd_addr);
                        wdata_nxt = cmd_data;
                    end
                end
            end
            FBP_ST_PROG: begin
                state_nxt = FBP_ST_IDLE;
                done_nxt  = 1'b1;
            end
            FBP_ST_ERASE: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == FBP_CNT_LAST) begin
                    state_nxt = FBP_ST_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = FBP_ST_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != FBP_ST_IDLE);
    end

    always_comb begin
        mem_wr_en   = (state_r == FBP_ST_PROG) || (state_r == FBP_ST_ERASE);
        mem_wr_addr = waddr_r;
        if (state_r == FBP_ST_ERASE) begin
            mem_wr_addr = {waddr_r[13:FBP_BLK_WORD_W], cnt_r};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= FBP_ST_IDLE;
            waddr_r <= '0;
            wdata_r <= '0;
            cnt_r   <= FBP_CNT_RST;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            err_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
            err_r   <= err_nxt;
        end
    end

    assign cmd_busy = busy_r;
    assign cmd_done = done_r;
    assign cmd_err  = err_r;

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    fbp_mem u_mem (
        .clk     (clk),
        .rd_en   (mem_rd_en),
        .rd_addr (fbp_word(rd_addr)),
        .rd_data (rd_data),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (wdata_r)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_take_erase;
        cmd_take && !cmd_deny && (cmd_op == FBP_OP_ERASE);
    endsequence

    sequence s_erase_body;
        busy_r [*8];
    endsequence

    property p_erase_len;
        @(posedge clk) disable iff (sys_rst)
        s_take_erase |=> s_erase_body ##248 (busy_r && !done_r) ##1 (done_r && !busy_r);
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

    property p_erase_ones;
        @(posedge clk) disable iff (sys_rst)
        (state_r == FBP_ST_ERASE) |-> (mem_wr_en && (wdata_r == FBP_ERASED_WORD));
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase not all ones");

    property p_erase_in_block;
        @(posedge clk) disable iff (sys_rst)
        (state_r == FBP_ST_ERASE) ##1 (state_r == FBP_ST_ERASE)
            |-> mem_wr_addr[13:8] == $past(mem_wr_addr[13:8]);
    endproperty
    a_erase_in_block: assert property (p_erase_in_block) else $error("erase left block");

    property p_free_unit;
        @(posedge clk) disable iff (sys_rst)
        (cmd_take && !ro_mask[fbp_unit(cmd_addr)] && !xo_mask[fbp_unit(cmd_addr)])
            |=> (busy_r && !err_r);
    endproperty
    a_free_unit: assert property (p_free_unit) else $error("free unit refused");

    property p_ro_refuse;
        @(posedge clk) disable iff (sys_rst)
        (cmd_take && ro_mask[fbp_unit(cmd_addr)]) |=> (err_r && done_r && !busy_r);
    endproperty
    a_ro_refuse: assert property (p_ro_refuse) else $error("read-only write taken");

    property p_xo_read;
        @(posedge clk) disable iff (sys_rst)
        (rd_req && xo_mask[fbp_unit(rd_addr)])
            |=> (rd_ack_r && (rd_err_r == ($past(rd_src) != FBP_SRC_IFETCH)));
    endproperty
    a_xo_read: assert property (p_xo_read) else $error("execute-only read wrong");

    property p_read_one_cycle;
        @(posedge clk) disable iff (sys_rst)
        (rd_req && !xo_mask[fbp_unit(rd_addr)]) |=> (rd_ack_r && !rd_err_r);
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle) else $error("read not single cycle");

    property p_refused_no_write;
        @(posedge clk) disable iff (sys_rst)
        (cmd_take && cmd_deny) |=> (!mem_wr_en && err_r) ##1 !mem_wr_en;
    endproperty
    a_refused_no_write: assert property (p_refused_no_write) else $error("refused op wrote");

endmodule // fbp_top

// >>> logic/fbp_pkg.sv
// Constants, types and helper functions of the flash block protection logic
package fbp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int FBP_ADDR_W     = 16;
    localparam int FBP_WORD_AW    = 14;
    localparam int FBP_DATA_W     = 32;
    localparam int FBP_UNIT_W     = 5;
    localparam int FBP_UNIT_CNT   = 32;
    localparam int FBP_UNIT_LSB   = 11;
    localparam int FBP_BLK_LSB    = 10;
    localparam int FBP_WORD_LSB   = 2;
    localparam int FBP_BLK_WORD_W = 8;
    localparam int FBP_BLK_WORDS  = 256;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [31:0] FBP_ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [7:0]  FBP_CNT_RST     = 8'h00;
    localparam logic [7:0]  FBP_CNT_LAST    = 8'hFF;

    typedef enum logic [1:0] {
        FBP_SRC_IFETCH = 2'b00,
        FBP_SRC_DATA   = 2'b01,
        FBP_SRC_DEBUG  = 2'b10
    } fbp_src_t;

    typedef enum logic {
        FBP_OP_PROG  = 1'b0,
        FBP_OP_ERASE = 1'b1
    } fbp_op_t;

    typedef enum logic [1:0] {
        FBP_ST_IDLE  = 2'b00,
        FBP_ST_PROG  = 2'b01,
        FBP_ST_ERASE = 2'b10
    } fbp_state_t;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    function automatic logic [4:0] fbp_unit(input logic [15:0] a);
        return a[FBP_UNIT_LSB +: FBP_UNIT_W];
    endfunction

    function automatic logic [13:0] fbp_word(input logic [15:0] a);
        return a[FBP_WORD_LSB +: FBP_WORD_AW];
    endfunction

endpackage : fbp_pkg

// >>> logic/fbp_mem.sv
// Flash storage array with registered read data
module fbp_mem
    import fbp_pkg::*;
(
    input  wire logic        clk,     // System clock
    input  wire logic        rd_en,   // Read strobe
    input  wire logic [13:0] rd_addr, // Read word address
    output logic      [31:0] rd_data, // Registered read data
    input  wire logic        wr_en,   // Write strobe
    input  wire logic [13:0] wr_addr, // Write word address
    input  wire logic [31:0] wr_data  // Write data
);

    logic [31:0] mem [0:(1 << FBP_WORD_AW) - 1];
    logic [31:0] rd_data_r;
    logic [31:0] rd_data_nxt;

    assign rd_data = rd_data_r;

    always_comb begin
        rd_data_nxt = rd_data_r;
        if (rd_en) begin
            rd_data_nxt = mem[rd_addr];
        end
    end

    always_ff @(posedge clk) begin
        rd_data_r <= rd_data_nxt;
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule // fbp_mem

// >>> tb/fbp_req_model.sv
// Requester model: fetch, data and debugger paths
module fbp_req_model
    import fbp_pkg::*;
(
    input  wire logic         clk,      // Clock
    input  wire logic         rd_ack,   // Read answered
    input  wire logic         rd_err,   // Read denied
    input  wire logic [31:0]  rd_data,  // Read data
    input  wire logic         cmd_busy, // Op running
    input  wire logic         cmd_done, // Op ended
    input  wire logic         cmd_err,  // Op refused
    output fbp_pkg::fbp_src_t rd_src,   // Path
    output logic              rd_req,   // Read request
    output logic [15:0]       rd_addr,  // Read address
    output logic              cmd_req,  // Op request
    output fbp_pkg::fbp_op_t  cmd_op,   // Op kind
    output logic [15:0]       cmd_addr, // Op address
    output logic [31:0]       cmd_data  // Op data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rd_req   = 1'b0;
        rd_src   = FBP_SRC_IFETCH;
        rd_addr  = 16'h0000;
        cmd_req  = 1'b0;
        cmd_op   = FBP_OP_PROG;
        cmd_addr = 16'h0000;
        cmd_data = 32'h00000000;
    end

    // Released address and data lines carry the inverse so stale values never match
    task automatic rd(input fbp_src_t s, input logic [15:0] a,
                      output logic ack, output logic err, output logic [31:0] d);
        @(posedge clk);
        rd_req  <= 1'b1;
        rd_src  <= s;
        rd_addr <= a;
        @(posedge clk);
        rd_req  <= 1'b0;
        rd_addr <= ~a;
        @(negedge clk);
        ack = rd_ack;
        err = rd_err;
        d   = rd_data;
    endtask

    task automatic cmd(input fbp_op_t op, input logic [15:0] a, input logic [31:0] d,
                       output int n, output int nb, output logic err);
        @(posedge clk);
        cmd_req  <= 1'b1;
        cmd_op   <= op;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk);
        cmd_req  <= 1'b0;
        cmd_addr <= ~a;
        cmd_data <= ~d;
        nb = 0;
        for (n = 1; n < 400; n++) begin
            @(negedge clk);
            if (cmd_done === 1'b1) break;
            if (cmd_busy === 1'b1) nb++;
        end
        err = cmd_err;
    endtask
endmodule // fbp_req_model

// >>> tb/tb_fbp_top.sv
// Self-checking testbench of the flash protection logic
module tb_fbp_top
    import fbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        sys_rst;
    logic [31:0] ro_mask;
    logic [31:0] xo_mask;
    fbp_src_t    rd_src;
    fbp_op_t     cmd_op;
    logic        rd_req, rd_ack, rd_err, cmd_req, cmd_busy, cmd_done, cmd_err;
    logic [15:0] rd_addr, cmd_addr;
    logic [31:0] rd_data, cmd_data, d;
    logic        ack, err;
    int          n, nb, n_fail, n_tests;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    fbp_top DUT (.clk(clk), .sys_rst(sys_rst), .ro_mask(ro_mask), .xo_mask(xo_mask),
        .rd_req(rd_req), .rd_src(rd_src), .rd_addr(rd_addr), .rd_ack(rd_ack),
        .rd_err(rd_err), .rd_data(rd_data), .cmd_req(cmd_req), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_busy(cmd_busy),
        .cmd_done(cmd_done), .cmd_err(cmd_err));

    fbp_req_model REQ (.clk(clk), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
        .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_err(cmd_err), .rd_src(rd_src),
        .rd_req(rd_req),
        .rd_addr(rd_addr), .cmd_req(cmd_req), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data));

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic rd_chk(input fbp_src_t s, input logic [15:0] a, input logic e_err,
                          input logic [31:0] e_d);
        REQ.rd(s, a, ack, err, d);
        chk({31'h0, ack}, 32'h1, "read ack");
        chk({31'h0, err}, {31'h0, e_err}, "read err");
        chk(d, e_d, "read data");
    endtask

    // Cycle count from take to done: 1 refused, 2 program, 257 erase
    task automatic op_chk(input fbp_op_t op, input logic [15:0] a, input logic [31:0] v,
                          input int e_n, input logic e_err);
        REQ.cmd(op, a, v, n, nb, err);
        if (n >= 400) begin
            n_fail++;
            tally_and_finish();
        end else begin
            chk(n, e_n, "op cycles");
            chk(nb, e_n - 1, "op busy cycles");
            chk({31'h0, cmd_busy}, 32'h0, "busy at done");
            chk({31'h0, err}, {31'h0, e_err}, "op err");
        end
    endtask

    task automatic t_erase();
        op_chk(FBP_OP_ERASE, 16'h0800, 32'h0, 257, 1'b0);
        rd_chk(FBP_SRC_IFETCH, 16'h0800, 1'b0, 32'hFFFFFFFF);
        rd_chk(FBP_SRC_DEBUG, 16'h0BFC, 1'b0, 32'hFFFFFFFF);
    endtask

    task automatic t_prog();
        op_chk(FBP_OP_PROG, 16'h0C04, 32'h12345678, 2, 1'b0);
        rd_chk(FBP_SRC_DATA, 16'h0C04, 1'b0, 32'h12345678);
        op_chk(FBP_OP_ERASE, 16'h0B00, 32'h0, 257, 1'b0);
        rd_chk(FBP_SRC_DATA, 16'h0C04, 1'b0, 32'h12345678);
    endtask

    task automatic t_ro();
        op_chk(FBP_OP_PROG, 16'h1000, 32'h5A5A5A5A, 2, 1'b0);
        @(posedge clk);
        ro_mask <= 32'h00000004;
        op_chk(FBP_OP_PROG, 16'h1000, 32'h0, 1, 1'b1);
        op_chk(FBP_OP_ERASE, 16'h17FC, 32'h0, 1, 1'b1);
        op_chk(FBP_OP_PROG, 16'h0FFC, 32'hA5A5A5A5, 2, 1'b0);
        rd_chk(FBP_SRC_DEBUG, 16'h1000, 1'b0, 32'h5A5A5A5A);
        rd_chk(FBP_SRC_DATA, 16'h0FFC, 1'b0, 32'hA5A5A5A5);
        @(posedge clk);
        ro_mask <= 32'h00000000;
    endtask

    task automatic t_xo();
        @(posedge clk);
        xo_mask <= 32'h00000002;
        op_chk(FBP_OP_PROG, 16'h0C04, 32'h0, 1, 1'b1);
        op_chk(FBP_OP_ERASE, 16'h0800, 32'h0, 1, 1'b1);
        rd_chk(FBP_SRC_IFETCH, 16'h0C04, 1'b0, 32'h12345678);
        rd_chk(FBP_SRC_DATA, 16'h0C04, 1'b1, 32'h12345678);
        rd_chk(FBP_SRC_DEBUG, 16'h0C04, 1'b1, 32'h12345678);
        rd_chk(FBP_SRC_DATA, 16'h1000, 1'b0, 32'h5A5A5A5A);
    endtask

    initial begin
        sys_rst = 1'b1;
        ro_mask = 32'h00000000;
        xo_mask = 32'h00000000;
        n_fail  = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_erase();
        t_prog();
        t_ro();
        t_xo();
        tally_and_finish();
    end
endmodule // tb_fbp_top
